// >>> dv/ligc_line_model.sv
// Receive line and board clock source model
`default_nettype none
module ligc_line_model (
	output var logic rx_bit_valid,
	output var logic rx_bit,
	output var logic mclk_tick_8x
);
	timeunit 1ns / 1ps;
	initial begin
		rx_bit_valid = 1'b0;
		rx_bit = 1'b0;
		mclk_tick_8x = 1'b0;
		#13;
		forever #160 mclk_tick_8x = ~mclk_tick_8x;
	end
	// Data is held well around the strobe, then shows the inverse
	task automatic send(input int n, input logic b);
		rx_bit = b;
		repeat (n) begin
			#80 rx_bit_valid = 1'b1;
			#160 rx_bit_valid = 1'b0;
			#80;
		end
		rx_bit = ~b;
	endtask
endmodule // ligc_line_model
`default_nettype wire

// >>> dv/ligc_top_chk.sv
// Port assertions for line global control
`default_nettype none
module ligc_top_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic receive_signal_loss_q,
	input wire logic master_clock_output_pin_oe_n_q,
	input wire logic receive_signal_loss_oe_n_q,
	input wire logic [3:0] input_clock_rate_code_q,
	input wire logic input_clock_rate_reserved_q
);
	timeunit 1ns / 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire [1:0] oe_n = {master_clock_output_pin_oe_n_q, receive_signal_loss_oe_n_q};
	wire [3:0] sel = reg_wdata[3:0];
	wire [3:0] cd = input_clock_rate_code_q;
	sequence s_ctl; reg_wr && reg_addr == 12'h0FE1; endsequence
	sequence s_sel; reg_wr && reg_addr == 12'h0FE4; endsequence
	a_ict_float: assert property (s_ctl ##0 reg_wdata[0] |=> ##1 oe_n == 2'b11)
		else $error("pins not floated");
	a_ict_release: assert property (s_ctl ##0 !reg_wdata[0] |=> ##1 oe_n == 2'b00)
		else $error("pins not driven");
	a_oe_cause: assert property ($changed(oe_n) |-> $past(reg_wr && reg_addr == 12'h0FE1, 2))
		else $error("enable moved alone");
	a_sel_base: assert property (s_sel ##0 (sel == 4'h0 || sel == 4'hE) |=> ##1 cd == 4'h1)
		else $error("2048 code wrong");
	a_sel_t1: assert property (s_sel ##0 (sel == 4'h1 || sel == 4'hF) |=> ##1 cd == 4'h2)
		else $error("1544 code wrong");
	a_sel_rsvd: assert property (s_sel ##0 (!sel[3] && sel[2:1] != 2'b00)
		|=> ##1 input_clock_rate_reserved_q && cd == 4'h0)
		else $error("reserved code wrong");
	a_sel_high: assert property (s_sel ##0 (sel[3] && sel < 4'hE)
		|=> ##1 cd == $past(sel, 2) - 4'h5)
		else $error("high code wrong");
	a_loss_clear: assert property ($rose(rx_bit_valid) && rx_bit
		|-> ##[1:8] !receive_signal_loss_q)
		else $error("loss not cleared");
endmodule // ligc_top_chk
bind ligc_top ligc_top_chk i_ligc_top_chk (.core_clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .rx_bit_valid, .rx_bit, .receive_signal_loss_q,
	.master_clock_output_pin_oe_n_q, .receive_signal_loss_oe_n_q,
	.input_clock_rate_code_q, .input_clock_rate_reserved_q);
`default_nettype wire

// >>> dv/ligc_top_tb.sv
// Self-checking bench for line global control
`default_nettype none
module ligc_top_tb;
	timeunit 1ns / 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_p = 1'b0;
	logic [7:0] d;
	logic [7:0] exp_q[$];
	logic [7:0] m[4] = '{8'h03, 8'hFF, 8'h30, 8'h0F};
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire [7:0] reg_rdata_q;
	wire [3:0] code;
	wire rx_bit_valid, rx_bit, mclk_tick_8x, loss, mco, mco_oe_n, loss_oe_n, rsvd;
	ligc_top i_ligc_top (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_q, .rx_bit_valid, .rx_bit, .mclk_tick_8x, .receive_signal_loss_q(loss),
		.master_clock_output_pin_q(mco), .master_clock_output_pin_oe_n_q(mco_oe_n),
		.receive_signal_loss_oe_n_q(loss_oe_n), .input_clock_rate_code_q(code),
		.input_clock_rate_reserved_q(rsvd));
	ligc_line_model i_ligc_line_model (.rx_bit_valid, .rx_bit, .mclk_tick_8x);
	initial forever #20 core_clk = ~core_clk;
	task automatic complete_run();
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	always @(posedge core_clk) begin
		rd_p <= reg_rd;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			complete_run();
		end
	end
	// Read data lands one edge after the strobe
	always @(negedge core_clk) if (rd_p) chk("rdata", exp_q.pop_front(), reg_rdata_q);
	task automatic cy(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] v);
		if (!w) exp_q.push_back(v);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_wdata = v;
		reg_wr = w;
		reg_rd = !w;
		@(posedge core_clk);
		#1 {reg_wr, reg_rd} = 2'b00;
	endtask
	function automatic logic [7:0] cexp(input logic [3:0] c);
		if (c == 4'h0 || c == 4'hE) return 8'h01;
		if (c == 4'h1 || c == 4'hF) return 8'h02;
		return c[3] ? {4'h0, c - 4'h5} : 8'h80;
	endfunction
	task automatic per(input logic [1:0] r);
		time t;
		d = $urandom;
		acc(1, 12'h0FE3, {d[7:6], r, d[3:0]});
		cy(300);
		@(posedge mco) t = $time;
		@(posedge mco) chk("mclk period", 8'h80 >> r, 8'(($time - t) / 40));
	endtask
	task automatic line(input int n, input logic b, input logic [7:0] e);
		i_ligc_line_model.send(n, b);
		cy(8);
		chk("loss", e, {7'h00, loss});
	endtask
	initial begin
		void'($urandom(15900));
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 5; i++) acc(0, 12'h0FE1 + 12'(i), 8'(i == 3));
		d = $urandom;
		for (int i = 0; i < 4; i++) acc(1, 12'h0FE1 + 12'(i), d);
		for (int i = 0; i < 4; i++) acc(0, 12'h0FE1 + 12'(i), d & m[i]);
		acc(1, 12'h0FE1, 8'h01);
		cy(2);
		chk("oe", 8'h03, {6'h00, mco_oe_n, loss_oe_n});
		acc(1, 12'h0FE1, 8'h00);
		cy(2);
		chk("oe", 8'h00, {6'h00, mco_oe_n, loss_oe_n});
		for (int c = 0; c < 16; c++) begin
			d = $urandom;
			acc(1, 12'h0FE4, {d[7:4], 4'(c)});
			cy(2);
			chk("rate code", cexp(4'(c)), {rsvd, 3'h0, code});
		end
		for (int r = 0; r < 4; r++) per(2'(r));
		line(174, 1'b0, 8'h00);
		line(1, 1'b0, 8'h01);
		line(1, 1'b1, 8'h00);
		acc(1, 12'h0FE1, 8'h02);
		line(4095, 1'b0, 8'h00);
		line(1, 1'b0, 8'h01);
		line(1, 1'b1, 8'h00);
		complete_run();
	end
endmodule // ligc_top_tb
`default_nettype wire

// >>> inc/ligc_map.vh
// Register map, field positions, reset values and timing counts for line global control
`ifndef LIGC_MAP_VH
`define LIGC_MAP_VH

`define LIGC_ADDR_W 12
`define LIGC_OFF_CTRL1 12'h0FE1
`define LIGC_OFF_CTRL2 12'h0FE2
`define LIGC_OFF_MCLK_OUT 12'h0FE3
`define LIGC_OFF_CLK_IN 12'h0FE4

`define LIGC_BIT_EXTENDED_LOSS_DETECT_ENABLE 1
`define LIGC_BIT_ICT 0
`define LIGC_MCO_HI 5
`define LIGC_MCO_LO 4
`define LIGC_CSEL_HI 3
`define LIGC_CSEL_LO 0

`define LIGC_RST_CTRL1 8'h00
`define LIGC_RST_CTRL2 8'h00
`define LIGC_RST_MCLK_OUT 8'h00
`define LIGC_RST_CLK_IN 8'h01
`define LIGC_MASK_CTRL1 8'h03
`define LIGC_MASK_MCLK_OUT 8'h30
`define LIGC_MASK_CLK_IN 8'h0F

`define LIGC_ZERO_EXT 13'h1000
`define LIGC_ZERO_STD 13'h00AF
`define LIGC_CNT_W 13

`define LIGC_MCO_1X 2'h0
`define LIGC_MCO_2X 2'h1
`define LIGC_MCO_4X 2'h2
`define LIGC_MCO_8X 2'h3

// Decoded input clock rate codes reported on the rate code port, zero for reserved selects
`define LIGC_CK_UNKNOWN 4'h0
`define LIGC_CK_2048 4'h1
`define LIGC_CK_1544 4'h2
`define LIGC_CK_4096 4'h3
`define LIGC_CK_3088 4'h4
`define LIGC_CK_8192 4'h5
`define LIGC_CK_6176 4'h6
`define LIGC_CK_16384 4'h7
`define LIGC_CK_12352 4'h8

`endif

// >>> rtl/ligc_mclk_div.v
// Master clock output divider: base tick divided by 16, 8, 4 or 2 for the 1X, 2X, 4X or 8X select
`default_nettype none
`include "ligc_map.vh"

module ligc_mclk_div (
	input wire core_clk,
	input wire rst,
	input wire tick_8x,
	input wire [1:0] rate_sel,
	output reg clk_out_q
);
	reg [2:0] div_q;
	reg toggle;

	always @* begin
		case (rate_sel)
			`LIGC_MCO_8X: toggle = 1'b1;
			`LIGC_MCO_4X: toggle = div_q[0];
			`LIGC_MCO_2X: toggle = div_q[1] & div_q[0];
			default: toggle = &div_q;
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			div_q <= 3'h0;
			clk_out_q <= 1'b0;
		end else if (tick_8x) begin
			div_q <= div_q + 3'h1;
			if (toggle) begin
				clk_out_q <= ~clk_out_q;
			end
		end
	end
endmodule // ligc_mclk_div
`default_nettype wire

// >>> rtl/ligc_top.v
// Line interface global control registers, loss detector, test tristate, clock rate
// Overview of operation
// RULE_01 - With extended loss detection set, loss of signal is declared after 4096 zeros.
// RULE_02 - With extended loss detection clear, loss of signal is declared after 175 zeros.
// RULE_03 - Setting in-circuit test enable floats every output pin of the device; here only the master clock output and receive signal loss pins float.
// RULE_04 - Clearing in-circuit test enable returns all output pins to normal drive.
// RULE_05 - The two-bit output rate field picks 1.544, 3.088, 6.176 or 12.352 MHz.
// RULE_06 - Input select codes 0000/1110 mean 2.048 MHz, 0001/1111 mean 1.544 MHz, 0010-0111 reserved.
// RULE_07 - Codes 1000-1101 mean 4.096, 3.088, 8.192, 6.176, 16.384 and 12.352 MHz.
// RULE_08 - The board must supply the input clock at the rate the select code names.
// RULE_09 - Software must set extended loss detection when the sync waveform mode is used.
// RULE_10 - The zero counter restarts whenever a one is received.
`default_nettype none
`include "ligc_map.vh"

module ligc_top (
	input wire core_clk,
	input wire rst,
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	input wire rx_bit_valid,
	input wire rx_bit,
	input wire mclk_tick_8x,
	output reg receive_signal_loss_q,
	output reg master_clock_output_pin_q,
	output reg master_clock_output_pin_oe_n_q,
	output reg receive_signal_loss_oe_n_q,
	output reg [3:0] input_clock_rate_code_q,
	output reg input_clock_rate_reserved_q
);
	////////////////////////////////////////////////////////////////////////////
	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [7:0] mclk_out_q;
	reg [7:0] clk_in_q;
	reg [2:0] rx_valid_sync_q;
	reg [2:0] rx_bit_sync_q;
	reg [2:0] tick_sync_q;
	reg valid_lvl_q;
	reg bit_lvl_q;
	reg tick_lvl_q;
	reg [`LIGC_CNT_W-1:0] zero_cnt_q;
	reg [`LIGC_CNT_W-1:0] zero_lim;
	wire extended_loss_detect_enable;
	wire in_circuit_test_enable;
	wire [1:0] master_clock_output_rate;
	wire [3:0] input_clock_rate_select;
	wire valid_rise;
	wire tick_rise;
	wire rx_data;
	wire mclk_raw;

	assign extended_loss_detect_enable = ctrl1_q[`LIGC_BIT_EXTENDED_LOSS_DETECT_ENABLE];
	assign in_circuit_test_enable = ctrl1_q[`LIGC_BIT_ICT];
	assign master_clock_output_rate = mclk_out_q[`LIGC_MCO_HI:`LIGC_MCO_LO];
	assign input_clock_rate_select = clk_in_q[`LIGC_CSEL_HI:`LIGC_CSEL_LO];

	////////////////////////////////////////////////////////////////////////////
	// Register port
	function [7:0] rd_mux;
		input [11:0] a;
		begin
			case (a)
				`LIGC_OFF_CTRL1: rd_mux = ctrl1_q;
				`LIGC_OFF_CTRL2: rd_mux = ctrl2_q;
				`LIGC_OFF_MCLK_OUT: rd_mux = mclk_out_q;
				`LIGC_OFF_CLK_IN: rd_mux = clk_in_q;
				default: rd_mux = 8'h00;
			endcase
		end
	endfunction

	always @(posedge core_clk) begin
		if (rst) begin
			ctrl1_q <= `LIGC_RST_CTRL1;
			ctrl2_q <= `LIGC_RST_CTRL2;
			mclk_out_q <= `LIGC_RST_MCLK_OUT;
			clk_in_q <= `LIGC_RST_CLK_IN;
			reg_rdata_q <= 8'h00;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`LIGC_OFF_CTRL1: ctrl1_q <= reg_wdata & `LIGC_MASK_CTRL1; // RULE_03 RULE_04
					`LIGC_OFF_CTRL2: ctrl2_q <= reg_wdata;
					`LIGC_OFF_MCLK_OUT: mclk_out_q <= reg_wdata & `LIGC_MASK_MCLK_OUT;
					`LIGC_OFF_CLK_IN: clk_in_q <= reg_wdata & `LIGC_MASK_CLK_IN;
					default: ctrl2_q <= ctrl2_q;
				endcase
			end
			if (reg_rd) begin
				reg_rdata_q <= rd_mux(reg_addr);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: change counts once second and third stages agree
	always @(posedge core_clk) begin
		if (rst) begin
			rx_valid_sync_q <= 3'h0;
			rx_bit_sync_q <= 3'h0;
			tick_sync_q <= 3'h0;
			valid_lvl_q <= 1'b0;
			bit_lvl_q <= 1'b0;
			tick_lvl_q <= 1'b0;
		end else begin
			rx_valid_sync_q <= {rx_valid_sync_q[1:0], rx_bit_valid};
			rx_bit_sync_q <= {rx_bit_sync_q[1:0], rx_bit};
			tick_sync_q <= {tick_sync_q[1:0], mclk_tick_8x};
			// Accepted level follows only once stages two and three agree
			if (rx_valid_sync_q[1] == rx_valid_sync_q[2]) begin
				valid_lvl_q <= rx_valid_sync_q[2];
			end
			if (rx_bit_sync_q[1] == rx_bit_sync_q[2]) begin
				bit_lvl_q <= rx_bit_sync_q[2];
			end
			if (tick_sync_q[1] == tick_sync_q[2]) begin
				tick_lvl_q <= tick_sync_q[2];
			end
		end
	end

	assign valid_rise = rx_valid_sync_q[2] & rx_valid_sync_q[1] & ~valid_lvl_q;
	assign tick_rise = tick_sync_q[2] & tick_sync_q[1] & ~tick_lvl_q;
	assign rx_data = bit_lvl_q;

	////////////////////////////////////////////////////////////////////////////
	// Consecutive-zero loss detector
	always @* begin
		if (extended_loss_detect_enable) begin
			zero_lim = `LIGC_ZERO_EXT; // RULE_01
		end else begin
			zero_lim = `LIGC_ZERO_STD; // RULE_02
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			zero_cnt_q <= {`LIGC_CNT_W{1'b0}};
			receive_signal_loss_q <= 1'b0;
		end else begin
			if (valid_rise) begin
				if (rx_data) begin
					zero_cnt_q <= {`LIGC_CNT_W{1'b0}}; // RULE_10
				end else if (zero_cnt_q < zero_lim) begin
					zero_cnt_q <= zero_cnt_q + 13'h0001;
				end
			end
			receive_signal_loss_q <= (zero_cnt_q >= zero_lim); // RULE_01 RULE_02
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Master clock output and output enables
	ligc_mclk_div u_div (
		.core_clk(core_clk),
		.rst(rst),
		.tick_8x(tick_rise),
		.rate_sel(master_clock_output_rate),
		.clk_out_q(mclk_raw)
	); // RULE_05

	always @(posedge core_clk) begin
		if (rst) begin
			master_clock_output_pin_q <= 1'b0;
			master_clock_output_pin_oe_n_q <= 1'b0;
			receive_signal_loss_oe_n_q <= 1'b0;
		end else begin
			master_clock_output_pin_q <= mclk_raw;
			master_clock_output_pin_oe_n_q <= in_circuit_test_enable; // RULE_03 RULE_04
			receive_signal_loss_oe_n_q <= in_circuit_test_enable; // RULE_03 RULE_04
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input clock rate decode
	function [3:0] ck_decode;
		input [3:0] c;
		begin
			case (c)
				4'h0, 4'hE: ck_decode = `LIGC_CK_2048; // RULE_06
				4'h1, 4'hF: ck_decode = `LIGC_CK_1544; // RULE_06
				4'h8: ck_decode = `LIGC_CK_4096; // RULE_07
				4'h9: ck_decode = `LIGC_CK_3088; // RULE_07
				4'hA: ck_decode = `LIGC_CK_8192; // RULE_07
				4'hB: ck_decode = `LIGC_CK_6176; // RULE_07
				4'hC: ck_decode = `LIGC_CK_16384; // RULE_07
				4'hD: ck_decode = `LIGC_CK_12352; // RULE_07
				default: ck_decode = `LIGC_CK_UNKNOWN;
			endcase
		end
	endfunction

	always @(posedge core_clk) begin
		if (rst) begin
			input_clock_rate_code_q <= `LIGC_CK_UNKNOWN;
			input_clock_rate_reserved_q <= 1'b0;
		end else begin
			input_clock_rate_code_q <= ck_decode(input_clock_rate_select); // RULE_06 RULE_07
			input_clock_rate_reserved_q <=
				(ck_decode(input_clock_rate_select) == `LIGC_CK_UNKNOWN);
		end
	end
endmodule // ligc_top
`default_nettype wire
